/* File: verilog/reset_stop_manager.sv */
// Reset and stop manager with watchdog, cause flags and boot hand-over.
`timescale 1ns/10ps
`default_nettype none
module reset_stop_manager
  import rsm_pkg::*;
#(
  parameter int RELEASE_COUNT = RELEASE_CYCLES,
  parameter bit ROMLESS       = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin_n,
  input  wire logic        halt_exec,
  input  wire logic        boot_done,
  input  wire logic [7:0]  rom_rdata,
  output logic      [15:0] rom_addr,
  output logic             rom_rd,
  output logic      [15:0] pc_value,
  output logic             pc_load,
  output logic             core_reset_n,
  output logic             io_weak_pullup,
  output logic             boot_active,
  output osc_ctl_t         osc_ctl,
  output logic             ext_mem_mode,
  output logic             mem_wait_insert,
  output logic             irq
);
  localparam int CW = $clog2(RELEASE_COUNT);

  // Whole state of the block.
  typedef struct packed {
    rsm_state_t        state;
    logic [CW-1:0]     cnt;
    logic              wdog_mode_select;
    logic              halt_reset_enable;
    logic              wdog_reset_flag;
    logic              sw_reset_flag;
    logic [15:0]       wd_period;
    logic [15:0]       wd_cnt;
    logic              wd_armed;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic              core_reset_n;
    logic              io_pullup;
    logic              boot_active;
    logic [15:0]       rom_addr;
    logic              rom_rd;
    logic [7:0]        pc_lo;
    logic [15:0]       pc_value;
    logic              pc_load;
    osc_ctl_t          osc;
    logic              ext_mem_mode;
    logic              mem_wait;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } rsm_regs_t;

  localparam rsm_regs_t REGS_RST = '{
    state:             ST_RESET,
    cnt:               '0,
    wdog_mode_select:  WDOG_MODE_RST,
    halt_reset_enable: HALT_RST_RST,
    wd_period:         WDOG_PERIOD_RST,
    wd_cnt:            WDOG_PERIOD_RST,
    irq_mask:          IRQ_MASK_RST,
    osc:               OSC_RUN,
    ext_mem_mode:      ROMLESS,
    mem_wait:          ROMLESS,
    default:           '0
  };

  rsm_regs_t q;
  rsm_regs_t next_q;
  logic      pin_low;

  // Filtered view of the external reset pin.
  reset_pin_filter #(
    .HOLD (GLITCH_CYCLES)
  ) u_pin_filter (
    .pclk        (pclk),
    .presetn     (presetn),
    .reset_pin_n (reset_pin_n),
    .pin_low     (pin_low)
  );

  // Bus phase and reset event decode.
  logic apb_setup;
  logic apb_write;
  logic wdog_on;
  logic sw_evt;
  logic wd_evt;
  logic halt_stop;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && q.pready && pwrite && !q.pslverr;
  // Watchdog mode is selected when the mode select bit is cleared.
  assign wdog_on   = !q.wdog_mode_select;
  assign sw_evt    = halt_exec && (q.state == ST_RUN) && q.halt_reset_enable;
  assign wd_evt    = wdog_on && (q.state == ST_RUN) && (q.wd_cnt == '0);
  assign halt_stop = halt_exec && (q.state == ST_RUN) && !q.halt_reset_enable
                     && !wdog_on;

  // Next-state logic for the bus slave, watchdog and reset sequence.
  always_comb begin
    logic [31:0] rdata;
    logic        mapped;
    rdata  = '0;
    mapped = 1'b1;
    next_q = q;
    next_q.pc_load = 1'b0;

    // Read decode happens in the setup phase; data stands for the access.
    case (paddr)
      ADDR_CTRL: begin
        rdata[CTRL_WDOG_MODE_BIT] = q.wdog_mode_select;
        rdata[CTRL_HALT_RST_BIT]  = q.halt_reset_enable;
      end
      ADDR_FLAG: begin
        rdata[FLAG_WDOG_BIT] = q.wdog_reset_flag;
        rdata[FLAG_SW_BIT]   = q.sw_reset_flag;
      end
      ADDR_SVC:    rdata = '0;
      ADDR_PERIOD: rdata[15:0] = q.wd_period;
      ADDR_STATUS: rdata[IRQ_W-1:0] = q.irq_status;
      ADDR_MASK:   rdata[IRQ_W-1:0] = q.irq_mask;
      default:     mapped = 1'b0;
    endcase
    next_q.pready  = apb_setup;
    next_q.pslverr = apb_setup && !mapped;
    if (apb_setup) begin
      next_q.prdata = rdata;
    end

    // Watchdog count runs only in normal operation.
    if (wdog_on && q.state == ST_RUN && q.wd_cnt != '0) begin
      next_q.wd_cnt = q.wd_cnt - 16'h0001;
    end

    // Register writes take effect at the end of the access phase.
    if (apb_write) begin
      case (paddr)
        ADDR_CTRL: begin
          next_q.wdog_mode_select  = pwdata[CTRL_WDOG_MODE_BIT];
          next_q.halt_reset_enable = pwdata[CTRL_HALT_RST_BIT];
          next_q.wd_cnt            = q.wd_period;
        end
        ADDR_SVC: begin
          // Of service writes, only the second key after the first, with no other service write between, reloads.
          if (pwdata[7:0] == WDOG_KEY_FIRST) begin
            next_q.wd_armed = 1'b1;
          end else if (pwdata[7:0] == WDOG_KEY_SECOND && q.wd_armed) begin
            next_q.wd_armed = 1'b0;
            next_q.wd_cnt   = q.wd_period;
          end else begin
            next_q.wd_armed = 1'b0;
          end
        end
        ADDR_PERIOD: begin
          next_q.wd_period = pwdata[15:0];
          next_q.wd_cnt    = pwdata[15:0];
        end
        ADDR_STATUS: next_q.irq_status = q.irq_status & ~pwdata[IRQ_W-1:0];
        ADDR_MASK:   next_q.irq_mask = pwdata[IRQ_W-1:0];
        default:     next_q.irq_mask = q.irq_mask;
      endcase
    end

    // Reset and stop sequence.
    case (q.state)
      ST_RESET: begin
        // Release is only seen once the filter confirms the pin high.
        next_q.state = ST_COUNT;
        next_q.cnt   = '0;
      end
      ST_COUNT: begin
        if (q.cnt == CW'(RELEASE_COUNT - 1)) begin
          next_q.state = ST_BOOT;
        end else begin
          next_q.cnt = q.cnt + CW'(1);
        end
      end
      ST_BOOT: begin
        // The core runs its boot routine; on boot_done this block fetches the vector.
        if (boot_done) begin
          next_q.state    = ST_VEC_LO;
          next_q.rom_addr = VEC_LO_ADDR;
          next_q.rom_rd   = 1'b1;
          next_q.cnt      = '0;
        end
      end
      ST_VEC_LO: begin
        next_q.rom_addr = VEC_HI_ADDR;
        next_q.state    = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        // Memory answers a cycle after the address: low byte, then high byte.
        if (q.cnt == '0) begin
          next_q.pc_lo = rom_rdata;
          next_q.cnt   = CW'(1);
        end else begin
          next_q.pc_value = {rom_rdata, q.pc_lo};
          next_q.pc_load  = 1'b1;
          next_q.rom_rd   = 1'b0;
          next_q.state    = ST_RUN;
        end
      end
      ST_RUN: begin
        // Internal sources never touch the pin, only the core reset.
        if (sw_evt) begin
          next_q.state           = ST_COUNT;
          next_q.cnt             = '0;
          next_q.sw_reset_flag   = 1'b1;
          next_q.wdog_reset_flag = 1'b0;
        end else if (wd_evt) begin
          next_q.state           = ST_COUNT;
          next_q.cnt             = '0;
          next_q.wdog_reset_flag = 1'b1;
          next_q.sw_reset_flag   = 1'b0;
        end else if (halt_stop) begin
          next_q.state = ST_HALT;
        end
      end
      ST_HALT: begin
        // Only a pin reset leaves halt; the pulse length is the source's job.
        next_q.state = ST_HALT;
      end
      default: begin
        next_q.state = ST_RESET;
      end
    endcase

    // The pin overrides every other condition and restarts the count.
    if (pin_low) begin
      next_q.state           = ST_RESET;
      next_q.cnt             = '0;
      next_q.sw_reset_flag   = 1'b0;
      next_q.wdog_reset_flag = 1'b0;
    end

    // Sticky event bits; a set in the clearing cycle wins.
    if (pin_low)   next_q.irq_status[IRQ_PIN_BIT]  = 1'b1;
    if (sw_evt)    next_q.irq_status[IRQ_SW_BIT]   = 1'b1;
    if (wd_evt)    next_q.irq_status[IRQ_WDOG_BIT] = 1'b1;
    if (halt_stop) next_q.irq_status[IRQ_HALT_BIT] = 1'b1;

    // Core reset stays low through the whole count without a gap.
    next_q.core_reset_n = !(next_q.state == ST_RESET
                            || next_q.state == ST_COUNT);
    next_q.io_pullup    = !next_q.core_reset_n;
    next_q.boot_active  = (next_q.state == ST_BOOT)
                          || (next_q.state == ST_VEC_LO)
                          || (next_q.state == ST_VEC_HI);

    // Control registers return to their defaults while reset is held.
    if (!next_q.core_reset_n) begin
      next_q.wdog_mode_select  = WDOG_MODE_RST;
      next_q.halt_reset_enable = HALT_RST_RST;
      next_q.wd_period         = WDOG_PERIOD_RST;
      next_q.wd_cnt            = WDOG_PERIOD_RST;
      next_q.wd_armed          = 1'b0;
      next_q.irq_mask          = IRQ_MASK_RST;
      next_q.rom_rd            = 1'b0;
      next_q.ext_mem_mode      = ROMLESS;
      next_q.mem_wait          = ROMLESS;
    end

    // Oscillator is stopped only in halt; its output floats then.
    next_q.osc = (next_q.state == ST_HALT) ? OSC_HALT : OSC_RUN;
    next_q.irq = |(next_q.irq_status & next_q.irq_mask);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= REGS_RST;
    end else begin
      q <= next_q;
    end
  end

  // Every output comes straight from the state register.
  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign rom_addr        = q.rom_addr;
  assign rom_rd          = q.rom_rd;
  assign pc_value        = q.pc_value;
  assign pc_load         = q.pc_load;
  assign core_reset_n    = q.core_reset_n;
  assign io_weak_pullup  = q.io_pullup;
  assign boot_active     = q.boot_active;
  assign osc_ctl         = q.osc;
  assign ext_mem_mode    = q.ext_mem_mode;
  assign mem_wait_insert = q.mem_wait;
  assign irq             = q.irq;

  // Cycles spent in the release count, for checking only.
  logic [9:0] count_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_len <= '0;
    end else if (q.state == ST_COUNT) begin
      count_len <= count_len + 10'h001;
    end else begin
      count_len <= '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pin_priority;
    pin_low |=> (q.state == ST_RESET) && !q.core_reset_n && q.io_pullup;
  endproperty
  a_pin_priority: assert property (p_pin_priority)
    else $error("pin reset did not take priority");

  property p_pin_fast;
    $rose(pin_low) |=> !q.core_reset_n && !q.sw_reset_flag && !q.wdog_reset_flag;
  endproperty
  a_pin_fast: assert property (p_pin_fast)
    else $error("pin reset not applied at once");

  property p_sw_flag;
    sw_evt && !pin_low |=> q.sw_reset_flag && !q.wdog_reset_flag && !q.core_reset_n;
  endproperty
  a_sw_flag: assert property (p_sw_flag)
    else $error("software reset cause not recorded");

  property p_wd_reset;
    wd_evt && !pin_low |=> q.wdog_reset_flag && !q.sw_reset_flag ##1 !q.core_reset_n;
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("watchdog expiry did not reset");

  property p_release_len;
    $rose(q.core_reset_n) |-> count_len == 10'(RELEASE_COUNT);
  endproperty
  a_release_len: assert property (p_release_len)
    else $error("release count length wrong");

  property p_vector;
    q.pc_load |-> q.pc_value == {$past(rom_rdata), $past(rom_rdata, 2)};
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector not loaded from low bytes");

  property p_halt_osc;
    q.state == ST_HALT |-> !q.osc.osc_out_oe && q.osc.clk_hold_high
                           && !q.osc.feedback_en && !q.osc.osc_enable;
  endproperty
  a_halt_osc: assert property (p_halt_osc)
    else $error("halt did not stop the oscillator");

  property p_osc_float;
    !q.osc.osc_enable |-> !q.osc.osc_out_oe;
  endproperty
  a_osc_float: assert property (p_osc_float)
    else $error("oscillator output driven while stopped");

  property p_halt_wdog;
    halt_exec && q.state == ST_RUN && wdog_on && !q.halt_reset_enable && !pin_low && !wd_evt
      |=> q.state == ST_RUN && q.osc.osc_enable;
  endproperty
  a_halt_wdog: assert property (p_halt_wdog)
    else $error("halt stopped oscillator under watchdog");
endmodule : reset_stop_manager
`default_nettype wire

/* File: verilog/rsm_pkg.sv */
// Constants and types shared by the reset and stop manager.
package rsm_pkg;
  // Clock rate and pin timing, with glitch and detect cycle counts derived from them.
  localparam int CLK_PERIOD_NS     = 8;
  localparam int GLITCH_NS         = 50;
  localparam int GLITCH_CYCLES     = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_MAX_NS     = 4000;
  localparam int DETECT_MAX_CYCLES = DETECT_MAX_NS / CLK_PERIOD_NS;
  localparam int RELEASE_CYCLES    = 510;

  // Register byte offsets on the APB.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FLAG   = 8'h04;
  localparam logic [7:0] ADDR_SVC    = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;

  // Field positions.
  localparam int CTRL_WDOG_MODE_BIT = 0;
  localparam int CTRL_HALT_RST_BIT  = 3;
  localparam int FLAG_SW_BIT        = 5;
  localparam int FLAG_WDOG_BIT      = 6;
  localparam int IRQ_PIN_BIT        = 0;
  localparam int IRQ_SW_BIT         = 1;
  localparam int IRQ_WDOG_BIT       = 2;
  localparam int IRQ_HALT_BIT       = 3;
  localparam int IRQ_W              = 4;

  // Reset values.
  localparam logic              WDOG_MODE_RST   = 1'b1;
  localparam logic              HALT_RST_RST    = 1'b0;
  localparam logic [15:0]       WDOG_PERIOD_RST = 16'hffff;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST    = 4'h0;

  // Watchdog service keys and reset vector location.
  localparam logic [7:0]  WDOG_KEY_FIRST  = 8'haa;
  localparam logic [7:0]  WDOG_KEY_SECOND = 8'h55;
  localparam logic [15:0] VEC_LO_ADDR     = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR     = 16'h0001;

  typedef enum logic [2:0] {
    ST_RESET, ST_COUNT, ST_BOOT, ST_VEC_LO, ST_VEC_HI, ST_RUN, ST_HALT
  } rsm_state_t;

  // Oscillator controls travel together.
  typedef struct packed {
    logic osc_enable;
    logic osc_out_oe;
    logic clk_hold_high;
    logic feedback_en;
    logic pll_ccu_stop;
  } osc_ctl_t;

  localparam osc_ctl_t OSC_RUN  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam osc_ctl_t OSC_HALT = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
endpackage : rsm_pkg

/* File: verilog/reset_pin_filter.sv */
// Glitch filter for the external reset pin.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_filter
  import rsm_pkg::*;
#(
  parameter int HOLD = GLITCH_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic reset_pin_n,
  output logic      pin_low
);
  localparam int CW = $clog2(HOLD + 1);

  typedef struct packed {
    logic          low;
    logic [CW-1:0] cnt;
  } filt_t;

  localparam filt_t FILT_RST = '{1'b1, '0};

  filt_t q;
  filt_t next_q;

  // A pin level must persist for HOLD cycles before the output follows it.
  always_comb begin
    next_q = q;
    if (!reset_pin_n != q.low) begin
      if (q.cnt == CW'(HOLD - 1)) begin
        next_q.low = !reset_pin_n;
        next_q.cnt = '0;
      end else begin
        next_q.cnt = q.cnt + CW'(1);
      end
    end else begin
      next_q.cnt = '0;
    end
  end

  // State register; the pin reads as asserted until proven released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= FILT_RST;
    end else begin
      q <= next_q;
    end
  end

  assign pin_low = q.low;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_long_low;
    !reset_pin_n [*7] |=> q.low;
  endproperty
  a_long_low: assert property (p_long_low)
    else $error("reset pin held low was not taken");

  property p_short_glitch;
    (!q.low && reset_pin_n) |=> !q.low;
  endproperty
  a_short_glitch: assert property (p_short_glitch)
    else $error("filter fell without a long low level");

  property p_release_seen;
    reset_pin_n [*7] |=> !q.low;
  endproperty
  a_release_seen: assert property (p_release_seen)
    else $error("pin release not detected in time");
endmodule : reset_pin_filter
`default_nettype wire

/* File: sim/reset_source_model.sv */
// Behavioural model of the external source that drives the reset pin.
`timescale 1ns/10ps
`default_nettype none
module reset_source_model #(
  parameter int LONG_CYCLES      = 2501,
  parameter int HALT_EXIT_CYCLES = 1500000,
  parameter int GLITCH_LOW       = 6
) (
  input  wire logic pclk,
  output logic      reset_pin_n
);
  // The pin idles high between pulses.
  initial reset_pin_n = 1'b1;

  // Drives the pin low for a number of cycles, then releases it high.
  task automatic pulse(input int cycles);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (cycles) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask : pulse

  // A low longer than the guaranteed minimum, so the reset is certain.
  task automatic long_low();
    pulse(LONG_CYCLES);
  endtask : long_low

  // A short low of 48 ns that the device must ignore.
  task automatic glitch();
    pulse(GLITCH_LOW);
  endtask : glitch

  // The long pulse that wakes the device from halt.
  task automatic halt_exit();
    pulse(HALT_EXIT_CYCLES);
  endtask : halt_exit
endmodule : reset_source_model
`default_nettype wire

/* File: sim/reset_stop_manager_tb_top.sv */
// Self-checking testbench for the reset and stop manager.
`timescale 1ns/10ps
`default_nettype none
module reset_stop_manager_tb_top;
  import rsm_pkg::*;
  localparam int RC = 40;
  logic        pclk, presetn, psel, penable, pwrite, halt_exec, boot_done;
  logic [7:0]  paddr, rom_rdata;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] rom_addr, pc_value;
  logic        pready, pslverr, rom_rd, pc_load, core_reset_n, io_weak_pullup;
  logic        boot_active, ext_mem_mode, mem_wait_insert, irq, errv;
  wire logic   reset_pin_n;
  osc_ctl_t    osc_ctl;
  int          failures, num_checks, n;

  reset_stop_manager #(.RELEASE_COUNT(RC), .ROMLESS(1'b0)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .halt_exec(halt_exec), .boot_done(boot_done),
    .rom_rdata(rom_rdata), .rom_addr(rom_addr), .rom_rd(rom_rd), .pc_value(pc_value),
    .pc_load(pc_load), .core_reset_n(core_reset_n), .io_weak_pullup(io_weak_pullup),
    .boot_active(boot_active), .osc_ctl(osc_ctl), .ext_mem_mode(ext_mem_mode),
    .mem_wait_insert(mem_wait_insert), .irq(irq));

  reset_source_model #(.HALT_EXIT_CYCLES(3000)) pin_u (.pclk(pclk), .reset_pin_n(reset_pin_n));

  // Clock at 125 MHz.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Memory model: the vector byte follows its address by one cycle.
  always @(posedge pclk) begin
    rom_rdata <= rom_addr[0] ? 8'h12 : 8'h34;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Compares a seen value against the expected one.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic hang(input string what);
    $display("BAD %s exp done seen timeout", what);
    failures++;
    give_verdict();
  endtask : hang

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The request stands until the edge at which pready is sampled high.
    do begin
      @(posedge pclk);
      k++;
      if (k > 50) hang("pready");
    end while (pready !== 1'b1);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdv, exp);
  endtask : rd_chk

  // Waits for the core reset level and counts the cycles taken.
  task automatic wait_core(input logic v);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (n > 6000) hang("core reset");
    end while (core_reset_n !== v);
  endtask : wait_core

  // Waits for the vector load and checks the hand-over.
  task automatic boot_check();
    logic ba;
    int   k;
    k  = 0;
    ba = 1'b0;
    forever begin
      @(negedge pclk);
      if (pc_load === 1'b1) break;
      ba = boot_active;
      k++;
      if (k > 100) hang("vector load");
    end
    check("boot before load", ba, 1'b1);
    check("pc vector", pc_value, 16'h1234);
  endtask : boot_check

  // One-cycle halt instruction pulse.
  task automatic halt_pulse();
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
  endtask : halt_pulse

  // Main sequence.
  initial begin
    failures   = 0;
    num_checks = 0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    halt_exec  = 1'b0;
    boot_done  = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_core(1'b1);
    boot_check();
    check("ext mem", {ext_mem_mode, mem_wait_insert}, 2'b00);
    check("osc run", osc_ctl, OSC_RUN);
    rd_chk("ctrl", ADDR_CTRL, 32'h1);
    rd_chk("period", ADDR_PERIOD, 32'hffff);
    rd_chk("flags", ADDR_FLAG, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", errv, 1'b1);
    pin_u.glitch();
    repeat (20) @(negedge pclk);
    check("glitch", core_reset_n, 1'b1);
    $display("test power-up done");
    // Serviced watchdog survives, then expires once service stops.
    wr(ADDR_PERIOD, 32'd60);
    wr(ADDR_CTRL, 32'h0);
    repeat (4) begin
      repeat (20) @(posedge pclk);
      wr(ADDR_SVC, {24'h0, WDOG_KEY_FIRST});
      wr(ADDR_SVC, {24'h0, WDOG_KEY_SECOND});
      @(negedge pclk);
      check("wdog served", core_reset_n, 1'b1);
    end
    halt_pulse();
    repeat (2) @(negedge pclk);
    check("halt ignored", osc_ctl, OSC_RUN);
    wait_core(1'b0);
    check("wdog expiry", n >= 45 && n <= 62, 1'b1);
    check("pin untouched", reset_pin_n, 1'b1);
    wait_core(1'b1);
    boot_check();
    rd_chk("wdog flag", ADDR_FLAG, 32'h40);
    wr(ADDR_FLAG, 32'h0);
    rd_chk("flag read-only", ADDR_FLAG, 32'h40);
    $display("test watchdog done");
    // Halt with reset enabled gives a software reset; then the interrupt path.
    wr(ADDR_CTRL, 32'h9);
    halt_pulse();
    wait_core(1'b0);
    check("sw reset", n <= 4, 1'b1);
    wait_core(1'b1);
    boot_check();
    rd_chk("sw flag", ADDR_FLAG, 32'h20);
    wr(ADDR_MASK, 32'h2);
    repeat (2) @(negedge pclk);
    check("irq raised", irq, 1'b1);
    wr(ADDR_MASK, 32'h0);
    repeat (2) @(negedge pclk);
    check("irq masked", irq, 1'b0);
    wr(ADDR_MASK, 32'h2);
    wr(ADDR_STATUS, 32'h2);
    repeat (2) @(negedge pclk);
    check("irq cleared", irq, 1'b0);
    $display("test software reset done");
    // Halt stops the oscillator; the pin wakes it and restores defaults.
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_PERIOD, 32'h1234);
    halt_pulse();
    repeat (2) @(negedge pclk);
    check("halt stop", osc_ctl, OSC_HALT);
    fork
      pin_u.halt_exit();
      begin
        repeat (100) @(negedge pclk);
        check("pin reset core", core_reset_n, 1'b0);
        check("pull-ups", io_weak_pullup, 1'b1);
      end
    join
    repeat (15) @(negedge pclk);
    check("count holds", core_reset_n, 1'b0);
    pin_u.long_low();
    wait_core(1'b1);
    check("release count", n >= RC - 1 && n <= RC + DETECT_MAX_CYCLES + 2, 1'b1);
    check("osc restarted", osc_ctl, OSC_RUN);
    boot_check();
    rd_chk("pin flags", ADDR_FLAG, 32'h0);
    rd_chk("period default", ADDR_PERIOD, 32'hffff);
    rd_chk("mask default", ADDR_MASK, 32'h0);
    rd_chk("ctrl default", ADDR_CTRL, 32'h1);
    $display("test halt and pin reset done");
    give_verdict();
  end
endmodule : reset_stop_manager_tb_top
`default_nettype wire
